// *** common/dgp_pkg.sv ***
// ============
// Shared constants for the dual GPIO port block
// ============
package dgp_pkg;

    // ============
    // Widths
    // ============
    localparam int DGP_AW = 8;            // Register address width
    localparam int DGP_DW = 8;            // Register data width
    localparam int DGP_PA_W = 5;          // First port pin count
    localparam int DGP_PB_W = 8;          // Second port pin count
    localparam int DGP_CHG_W = 4;         // Change-detect pin count
    localparam int DGP_CHG_LSB = 4;       // Lowest change-detect pin

    // ============
    // Register offsets
    // ============
    localparam logic [7:0] OFS_PA_DATA = 8'h05;
    localparam logic [7:0] OFS_PB_DATA = 8'h06;
    localparam logic [7:0] OFS_INTERRUPT_CONTROL_REG = 8'h0b;
    localparam logic [7:0] OFS_CMP_CTRL = 8'h1f;
    localparam logic [7:0] OFS_OPTION = 8'h81;
    localparam logic [7:0] OFS_PA_DIR = 8'h85;
    localparam logic [7:0] OFS_PB_DIR = 8'h86;
    localparam logic [7:0] OFS_VREF_CTRL = 8'h9f;

    // ============
    // Reset values
    // ============
    localparam logic [7:0] RST_PA_DATA = 8'h00;
    localparam logic [7:0] RST_PB_DATA = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_CONTROL_REG = 8'h00;
    localparam logic [7:0] RST_CMP_CTRL = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [7:0] RST_PA_DIR = 8'h1f;
    localparam logic [7:0] RST_PB_DIR = 8'hff;
    localparam logic [7:0] RST_VREF_CTRL = 8'h00;

    // ============
    // Field positions and writable masks
    // ============
    localparam int BIT_PULLUP_N = 7;      // Option: pull-up enable, low
    localparam int BIT_CHG_FLAG = 0;      // Interrupt control: change
    localparam int BIT_C2OUT = 7;         // Comparator 2 output status
    localparam int BIT_C1OUT = 6;         // Comparator 1 output status
    localparam int BIT_VREN = 7;          // Reference enable
    localparam int BIT_VROE = 6;          // Reference output enable
    localparam int BIT_PA_VREF = 2;       // Pin carrying the reference
    localparam int BIT_PA_TCK = 4;        // Pin shared with timer clock
    localparam logic [7:0] MASK_CMP_WR = 8'h0f;
    localparam logic [7:0] MASK_VREF_WR = 8'hef;
    localparam logic [7:0] MASK_PA = 8'h1f;

    // ============
    // Comparator modes that touch the pins
    // ============
    localparam logic [2:0] CM_OFF = 3'h7;     // All pins digital
    localparam logic [2:0] CM_OUTPUTS = 3'h6; // Outputs on bits 3, 4
    localparam logic [4:0] AMASK_OFF = 5'h00;
    localparam logic [4:0] AMASK_OUT = 5'h07;
    localparam logic [4:0] AMASK_ALL = 5'h0f;
    localparam logic [4:0] PA_OD_MASK = 5'h10; // Bit 4 is open drain
    localparam logic [4:0] PA_CMP_OUT_PINS = 5'h18;

endpackage

// *** design/dgp_sync2.sv ***
`timescale 1ns/100ps
// ============================================================
// Two flip-flop synchroniser for a bus of pin levels
// ============================================================
module dgp_sync2 #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // First stage, read only by the second stage
    logic [W-1:0] meta;

    // ========================================================
    // Both stages clear on reset to a known level
    // ========================================================
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // dgp_sync2

// *** design/dgp_pin_drive.sv ***
`timescale 1ns/100ps
// ============================================================
// Registered pin driver for one port
// ============================================================
module dgp_pin_drive #(
    parameter int W = 8,
    parameter logic [W-1:0] OD_MASK = '0
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] latch,
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] alt_en,
    input wire logic [W-1:0] alt_val,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n
);
    // Value offered to the pin, latch or alternate function
    logic [W-1:0] value;
    // Next pin value and next enable
    logic [W-1:0] next_out;
    logic [W-1:0] next_oe_n;

    // Alternate function replaces the latch, direction still rules
    assign value = (alt_en & alt_val) | (~alt_en & latch);
    // Open-drain bits only ever pull low
    assign next_out = value & ~OD_MASK;
    // Direction 1 floats the driver, 0 drives the chosen value
    assign next_oe_n = dir | (OD_MASK & value);

    // ========================================================
    // Outputs from flip-flops; reset floats every pin
    // ========================================================
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe_n <= '1;
        end else begin
            pin_out <= next_out;
            pin_oe_n <= next_oe_n;
        end
    end
endmodule // dgp_pin_drive

// *** design/dgp_gpio_top.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - First port latch is five bits
// - First port bit4 open drain, others push-pull
// - First port bit4 feeds timer clock
// - Direction 1 floats pin, 0 drives latch
// - Data read gives pins, write sets latch
// - Writes act as read-modify-write
// - Comparator input pins read as zero
// - Reset: first port inputs, analog, grounded
// - Direction still drives comparator pins
// - Comparator outputs reach bits 3, 4
// - Unimplemented bits read as zero
// - Enabled peripheral takes pin from GPIO
// - Second port eight bits with direction
// - Active-low option bit enables pull-ups
// - Output pins lose their pull-up
// - Pull-ups off after power-on reset
// - Only upper input pins detect changes
// - Mismatches ORed into change flag
// - Persisting mismatch keeps setting flag
// - Change can wake from sleep
module dgp_gpio_top
    import dgp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [dgp_pkg::DGP_AW-1:0] reg_addr,
    input wire logic [dgp_pkg::DGP_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dgp_pkg::DGP_DW-1:0] reg_rdata,
    // First port pins
    input wire logic [dgp_pkg::DGP_PA_W-1:0] first_port_pin_in,
    output logic [dgp_pkg::DGP_PA_W-1:0] first_port_pin_out,
    output logic [dgp_pkg::DGP_PA_W-1:0] first_port_pin_oe_n,
    // Second port pins
    input wire logic [dgp_pkg::DGP_PB_W-1:0] second_port_pin_in,
    output logic [dgp_pkg::DGP_PB_W-1:0] second_port_pin_out,
    output logic [dgp_pkg::DGP_PB_W-1:0] second_port_pin_oe_n,
    output logic [dgp_pkg::DGP_PB_W-1:0] second_port_pullup_en,
    // Comparator and reference hookup
    input wire logic [1:0] comparator_out,
    output logic [dgp_pkg::DGP_PA_W-1:0] comparator_analog_sel,
    output logic comparator_inputs_grounded,
    output logic vref_on_pin,
    // Timer and wake
    output logic timer_external_clock_in,
    output logic change_interrupt_flag,
    output logic wake_request
);
    import dgp_pkg::*;

    // ============
    // Helper functions
    // ============

    // Pins given to the comparator for each mode
    function automatic logic [4:0] analog_mask(input logic [2:0] cm);
        logic [4:0] m;
        m = AMASK_ALL;
        if (cm == CM_OFF) begin
            m = AMASK_OFF;
        end else if (cm == CM_OUTPUTS) begin
            m = AMASK_OUT;
        end
        return m;
    endfunction

    // Address compare shared by the read and write decoders
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ============
    // Registers held by software
    // ============
    logic [DGP_PA_W-1:0] pa_latch;       // First port output latch
    logic [DGP_PA_W-1:0] pa_dir;         // First port direction
    logic [DGP_PB_W-1:0] pb_latch;       // Second port output latch
    logic [DGP_PB_W-1:0] pb_dir;         // Second port direction
    logic [7:0] cmp_ctrl;                // Comparator control
    logic [7:0] vref_ctrl;               // Reference control
    logic [7:0] option_reg;              // Option register
    logic [7:0] interrupt_control_reg;                  // Interrupt control
    logic [DGP_CHG_W-1:0] chg_ref;       // Change-detect reference

    // ============
    // Synchronised pins
    // ============
    logic [DGP_PA_W-1:0] pa_sync;        // First port pin levels
    logic [DGP_PB_W-1:0] pb_sync;        // Second port pin levels

    // Pins cross into the core clock before anything looks at them
    dgp_sync2 #(.W(DGP_PA_W)) u_sync_pa (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(first_port_pin_in),
        .sync_out(pa_sync)
    );

    dgp_sync2 #(.W(DGP_PB_W)) u_sync_pb (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(second_port_pin_in),
        .sync_out(pb_sync)
    );

    // ============
    // Address decode
    // ============
    wire sel_pa = hit(reg_addr, OFS_PA_DATA);
    wire sel_pb = hit(reg_addr, OFS_PB_DATA);
    wire sel_ic = hit(reg_addr, OFS_INTERRUPT_CONTROL_REG);
    wire sel_cm = hit(reg_addr, OFS_CMP_CTRL);
    wire sel_op = hit(reg_addr, OFS_OPTION);
    wire sel_pad = hit(reg_addr, OFS_PA_DIR);
    wire sel_pbd = hit(reg_addr, OFS_PB_DIR);
    wire sel_vr = hit(reg_addr, OFS_VREF_CTRL);

    wire wr_pa = reg_wr & sel_pa;
    wire wr_pb = reg_wr & sel_pb;
    wire wr_ic = reg_wr & sel_ic;
    wire wr_cm = reg_wr & sel_cm;
    wire wr_op = reg_wr & sel_op;
    wire wr_pad = reg_wr & sel_pad;
    wire wr_pbd = reg_wr & sel_pbd;
    wire wr_vr = reg_wr & sel_vr;

    // A write to the second port also reads it first, so both
    // accesses refresh the change reference
    wire pb_access = (reg_rd | reg_wr) & sel_pb;

    // ============
    // Pin sharing on the first port
    // ============
    wire [4:0] amask = analog_mask(cmp_ctrl[2:0]);
    // Reference output takes bit2 when enabled and routed out
    wire vref_live = vref_ctrl[BIT_VREN] & vref_ctrl[BIT_VROE];
    wire [4:0] vref_mask = {2'b00, vref_live, 2'b00};
    // Pins no longer usable as general inputs
    wire [4:0] pa_taken = amask | vref_mask;
    // Comparator outputs replace the latch on bits 3 and 4
    wire cmp_out_mode = (cmp_ctrl[2:0] == CM_OUTPUTS);
    wire [4:0] pa_alt_en = cmp_out_mode ? PA_CMP_OUT_PINS : 5'h00;
    wire [4:0] pa_alt_val = {comparator_out, 3'b000};

    // Taken pins read as zero, unimplemented upper bits too
    wire [7:0] pa_read = {3'b000, pa_sync & ~pa_taken};

    // ============
    // Change detection on the upper second-port pins
    // ============
    wire [3:0] chg_pins = pb_sync[DGP_CHG_LSB +: DGP_CHG_W];
    // Direction 1 means input; outputs are left out
    wire [3:0] chg_part = pb_dir[DGP_CHG_LSB +: DGP_CHG_W];
    wire [3:0] chg_diff = (chg_pins ^ chg_ref) & chg_part;
    // Any single mismatch raises the flag
    wire mismatch = |chg_diff;

    // Mismatch only counts against the reference in force; on the
    // access cycle the reference is replaced, so the flag is not
    // re-armed by a stale comparison then
    wire chg_set = mismatch & ~pb_access;

    // ============
    // Read mux, unmapped offsets read as zero
    // ============
    logic [7:0] next_rdata;
    assign next_rdata =
        sel_pa ? pa_read :
        sel_pb ? pb_sync :
        sel_ic ? interrupt_control_reg :
        sel_cm ? {comparator_out[1], comparator_out[0],
                  2'b00, cmp_ctrl[3:0]} :
        sel_op ? option_reg :
        sel_pad ? {3'b000, pa_dir} :
        sel_pbd ? pb_dir :
        sel_vr ? (vref_ctrl & MASK_VREF_WR) :
        8'h00;

    // ============
    // Interrupt control next value; set beats clear
    // ============
    logic [7:0] next_interrupt_control_reg;
    always_comb begin
        next_interrupt_control_reg = interrupt_control_reg;
        if (wr_ic) begin
            next_interrupt_control_reg = reg_wdata;
        end
        if (chg_set) begin
            // Hardware set wins over a software clear
            next_interrupt_control_reg[BIT_CHG_FLAG] = 1'b1;
        end
    end

    // ============
    // Read data, registered one cycle after the strobe
    // ============
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            // Data stand only in the cycle after the read
            reg_rdata <= 8'h00;
        end
    end

    // ============
    // First port registers
    // ============
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pa_latch <= RST_PA_DATA[4:0];
            pa_dir <= RST_PA_DIR[4:0];
        end else begin
            if (wr_pa) begin
                // Software sampled, modified, now stores the latch
                pa_latch <= reg_wdata[4:0];
            end
            if (wr_pad) begin
                pa_dir <= reg_wdata[4:0];
            end
        end
    end

    // ============
    // Second port registers
    // ============
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pb_latch <= RST_PB_DATA;
            pb_dir <= RST_PB_DIR;
        end else begin
            if (wr_pb) begin
                pb_latch <= reg_wdata;
            end
            if (wr_pbd) begin
                pb_dir <= reg_wdata;
            end
        end
    end

    // ============
    // Control registers
    // ============
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_ctrl <= RST_CMP_CTRL;
            vref_ctrl <= RST_VREF_CTRL;
            option_reg <= RST_OPTION;
            interrupt_control_reg <= RST_INTERRUPT_CONTROL_REG;
        end else begin
            if (wr_cm) begin
                // Output status bits are live, not stored
                cmp_ctrl <= reg_wdata & MASK_CMP_WR;
            end
            if (wr_vr) begin
                vref_ctrl <= reg_wdata & MASK_VREF_WR;
            end
            if (wr_op) begin
                option_reg <= reg_wdata;
            end
            interrupt_control_reg <= next_interrupt_control_reg;
        end
    end

    // ============
    // Change reference, reloaded by each second-port access
    // ============
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chg_ref <= '0;
        end else if (pb_access) begin
            chg_ref <= chg_pins;
        end
    end

    // ============
    // Pin drivers, outputs registered inside
    // ============
    // Direction keeps control even of comparator and reference
    // pins; software must leave those as inputs
    dgp_pin_drive #(.W(DGP_PA_W), .OD_MASK(PA_OD_MASK)) u_drv_pa (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .latch(pa_latch),
        .dir(pa_dir),
        .alt_en(pa_alt_en),
        .alt_val(pa_alt_val),
        .pin_out(first_port_pin_out),
        .pin_oe_n(first_port_pin_oe_n)
    );

    dgp_pin_drive #(.W(DGP_PB_W), .OD_MASK(8'h00)) u_drv_pb (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .latch(pb_latch),
        .dir(pb_dir),
        .alt_en(8'h00),
        .alt_val(8'h00),
        .pin_out(second_port_pin_out),
        .pin_oe_n(second_port_pin_oe_n)
    );

    // ============
    // Status and side outputs, all from flip-flops
    // ============
    // Pull-ups only where the option bit is low and pin is input
    wire [7:0] next_pullup = option_reg[BIT_PULLUP_N] ? 8'h00 : pb_dir;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            second_port_pullup_en <= 8'h00;
            comparator_analog_sel <= AMASK_ALL;
            comparator_inputs_grounded <= 1'b1;
            vref_on_pin <= 1'b0;
            timer_external_clock_in <= 1'b0;
            change_interrupt_flag <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            second_port_pullup_en <= next_pullup;
            comparator_analog_sel <= amask;
            // Reset mode grounds the comparator inputs to save current
            comparator_inputs_grounded <= (cmp_ctrl[2:0] == RST_CMP_CTRL[2:0]);
            vref_on_pin <= vref_live;
            // Timer sees the synchronised bit4 pin level
            timer_external_clock_in <= pa_sync[BIT_PA_TCK];
            change_interrupt_flag <= next_interrupt_control_reg[BIT_CHG_FLAG];
            // Wake follows the flag so sleep ends on any change at an upper second-port input pin
            wake_request <= next_interrupt_control_reg[BIT_CHG_FLAG];
        end
    end

endmodule // dgp_gpio_top

// *** testbench/dgp_gpio_chk.sv ***
`timescale 1ns/100ps
// ============
// Port checker for the dual GPIO block
// ============
module dgp_gpio_chk
    import dgp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] first_port_pin_in,
    input wire logic [4:0] first_port_pin_out,
    input wire logic [7:0] second_port_pin_in,
    input wire logic [7:0] second_port_pin_oe_n,
    input wire logic [7:0] second_port_pullup_en,
    input wire logic vref_on_pin,
    input wire logic timer_external_clock_in,
    input wire logic change_interrupt_flag,
    input wire logic wake_request
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Pin history is meaningless until the synchronisers refill
    logic [1:0] up_cnt;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_pa_upper_zero: assert property (
        reg_rd && (reg_addr == OFS_PA_DATA || reg_addr == OFS_PA_DIR)
        |=> reg_rdata[7:5] == 3'h0) else $error("upper bits not zero");
    chk_od_never_high: assert property (
        first_port_pin_out[4] == 1'b0) else $error("bit4 driven high");
    chk_dir_to_oe: assert property (
        reg_wr && reg_addr == OFS_PB_DIR |-> ##2
        second_port_pin_oe_n == $past(reg_wdata, 2))
        else $error("direction not on enables");
    chk_pullup_output: assert property (
        (second_port_pullup_en & ~second_port_pin_oe_n) == 8'h00)
        else $error("pull-up on output pin");
    chk_wake_flag: assert property (
        wake_request == change_interrupt_flag) else $error("wake differs");
    chk_timer_follow: assert property (
        up_cnt == 2'h3 |->
        timer_external_clock_in == $past(first_port_pin_in[4], 3))
        else $error("timer clock not following pin");
    chk_pb_read_sync: assert property (
        reg_rd && reg_addr == OFS_PB_DATA && up_cnt == 2'h3
        |=> reg_rdata == $past(second_port_pin_in, 3))
        else $error("port read not synced pins");
    chk_vref_route: assert property (
        reg_wr && reg_addr == OFS_VREF_CTRL |-> ##2
        vref_on_pin == (&$past(reg_wdata[7:6], 2)))
        else $error("reference routing wrong");
    chk_flag_clear: assert property (
        $fell(change_interrupt_flag) |->
        $past(reg_wr) && $past(reg_addr) == OFS_INTERRUPT_CONTROL_REG)
        else $error("flag fell without clear");
    cov_flag: cover property ($rose(change_interrupt_flag));
    cov_vref: cover property ($rose(vref_on_pin));
    cov_pb_read: cover property (reg_rd && reg_addr == OFS_PB_DATA);
endmodule // dgp_gpio_chk

bind dgp_gpio_top dgp_gpio_chk u_chk (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .first_port_pin_in, .first_port_pin_out,
    .second_port_pin_in, .second_port_pin_oe_n, .second_port_pullup_en,
    .vref_on_pin, .timer_external_clock_in, .change_interrupt_flag,
    .wake_request
);

// *** testbench/dgp_pin_model.sv ***
`timescale 1ns/100ps
// ============
// Board circuits on one port: drivers, pulls, loads
// ============
module dgp_pin_model #(
    parameter int W = 8,
    parameter logic [W-1:0] PULL = '0 // Board pull-up resistors
) (
    input wire logic sys_clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe_n,
    input wire logic [W-1:0] pullup_en,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] level
);
    logic [W-1:0] last = '0; // Level of the previous cycle
    logic [W-1:0] held; // Pulled high when nobody drives
    logic [W-1:0] free; // Released and unpulled
    assign held = PULL | pullup_en;
    assign free = pin_oe_n & ~ext_en & ~held;
    // Device driver wins; outside drivers only act on released pins
    assign level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & held) | (free & ~last);
    // A floating pin toggles so a stale value never looks valid
    always @(posedge sys_clk) begin
        last <= level;
    end
endmodule // dgp_pin_model

// *** testbench/dgp_gpio_top_tb.sv ***
`timescale 1ns/100ps
// ============
// Bench: register calls and pin checks
// ============
module dgp_gpio_top_tb;
    import dgp_pkg::*;
    logic sys_clk, sys_rst, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] first_port_pin_in, first_port_pin_out, first_port_pin_oe_n;
    logic [7:0] second_port_pin_in, second_port_pin_out;
    logic [7:0] second_port_pin_oe_n, second_port_pullup_en, ext_b_en, ext_b;
    logic [4:0] comparator_analog_sel, ext_a_en, ext_a;
    logic [1:0] comparator_out;
    logic comparator_inputs_grounded, vref_on_pin, timer_external_clock_in;
    logic change_interrupt_flag, wake_request;
    int failures, checks;
    // Reset readback; last entry is unmapped
    localparam logic [7:0] T_OFS [8] = '{OFS_PA_DIR, OFS_PB_DIR, OFS_OPTION,
        OFS_INTERRUPT_CONTROL_REG, OFS_CMP_CTRL, OFS_VREF_CTRL, OFS_PA_DATA, 8'h40};
    localparam logic [7:0] T_RST [8] = '{RST_PA_DIR, RST_PB_DIR, RST_OPTION,
        RST_INTERRUPT_CONTROL_REG, RST_CMP_CTRL, RST_VREF_CTRL, 8'h10, 8'h00};
    `define CHK(n, e, g) cmp(n, e, g)
    dgp_gpio_top u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .first_port_pin_in, .first_port_pin_out,
        .first_port_pin_oe_n, .second_port_pin_in, .second_port_pin_out,
        .second_port_pin_oe_n, .second_port_pullup_en, .comparator_out,
        .comparator_analog_sel, .comparator_inputs_grounded, .vref_on_pin,
        .timer_external_clock_in, .change_interrupt_flag, .wake_request);
    // Bit4 is open drain, so the board carries its pull-up
    dgp_pin_model #(.W(5), .PULL(PA_OD_MASK)) u_pa (.sys_clk,
        .pin_out(first_port_pin_out), .pin_oe_n(first_port_pin_oe_n),
        .pullup_en(5'h00), .ext_en(ext_a_en), .ext_val(ext_a),
        .level(first_port_pin_in));
    dgp_pin_model #(.W(8)) u_pb (.sys_clk, .pin_out(second_port_pin_out),
        .pin_oe_n(second_port_pin_oe_n), .pullup_en(second_port_pullup_en),
        .ext_en(ext_b_en), .ext_val(ext_b), .level(second_port_pin_in));
    task automatic cmp(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        cmp("rdata", e, reg_rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, comparator_out} = '0;
        {ext_a_en, ext_a, ext_b_en, ext_b} = {5'h1f, 5'h15, 8'hff, 8'h00};
        sys_rst = 1'b1;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        tick(1);
        `CHK("analog_sel", AMASK_ALL, comparator_analog_sel);
        `CHK("grounded", 1'b1, comparator_inputs_grounded);
        `CHK("pa_oe_n", 5'h1f, first_port_pin_oe_n);
        `CHK("pullup", 8'h00, second_port_pullup_en);
        for (int i = 0; i < 8; i++) rdc(T_OFS[i], T_RST[i]);
        $display("test reset done");
        wr(OFS_CMP_CTRL, 8'h07);
        ext_a_en <= 5'h00;
        wr(OFS_PA_DATA, 8'h1f);
        wr(OFS_PA_DIR, 8'h00);
        tick(2);
        `CHK("pa_out", 5'h0f, first_port_pin_out);
        `CHK("pa_oe_n", 5'h10, first_port_pin_oe_n);
        rdc(OFS_PA_DATA, 8'h1f);
        wr(OFS_PA_DATA, 8'h0a);
        tick(2);
        `CHK("pa_oe_n", 5'h00, first_port_pin_oe_n);
        {ext_a_en, ext_a} <= {5'h01, 5'h01};
        wr(OFS_PA_DIR, 8'h01);
        tick(2);
        rdc(OFS_PA_DATA, 8'h0b);
        wr(OFS_PA_DATA, 8'h0f);
        wr(OFS_PA_DIR, 8'h00);
        tick(2);
        `CHK("pa_out", 5'h0f, first_port_pin_out);
        $display("test first port done");
        comparator_out <= 2'b01;
        wr(OFS_CMP_CTRL, 8'h06);
        tick(2);
        `CHK("analog_sel", AMASK_OUT, comparator_analog_sel);
        `CHK("pa_out", 5'h0f, first_port_pin_out);
        comparator_out <= 2'b10;
        tick(2);
        `CHK("pa_out", 5'h07, first_port_pin_out);
        `CHK("pa_oe_n", 5'h10, first_port_pin_oe_n);
        rdc(OFS_CMP_CTRL, 8'h86);
        rdc(OFS_PA_DATA, 8'h10);
        wr(OFS_CMP_CTRL, 8'h07);
        wr(OFS_PA_DIR, 8'h1f);
        {ext_a_en, ext_a} <= {5'h1f, 5'h1f};
        wr(OFS_VREF_CTRL, 8'hff);
        tick(2);
        `CHK("vref_pin", 1'b1, vref_on_pin);
        `CHK("timer_clk", 1'b1, timer_external_clock_in);
        rdc(OFS_VREF_CTRL, 8'hef);
        rdc(OFS_PA_DATA, 8'h1b);
        $display("test comparator done");
        wr(OFS_OPTION, 8'h7f);
        tick(2);
        `CHK("pullup", 8'hff, second_port_pullup_en);
        ext_b_en <= 8'h00;
        wr(OFS_PB_DATA, 8'ha5);
        wr(OFS_PB_DIR, 8'h0f);
        tick(2);
        `CHK("pullup", 8'h0f, second_port_pullup_en);
        `CHK("pb_oe_n", 8'h0f, second_port_pin_oe_n);
        `CHK("pb_out", 8'ha0, second_port_pin_out & 8'hf0);
        rdc(OFS_PB_DATA, 8'haf);
        wr(OFS_INTERRUPT_CONTROL_REG, 8'h00);
        wr(OFS_PB_DATA, 8'h50);
        tick(4);
        `CHK("flag", 1'b0, change_interrupt_flag);
        {ext_b_en, ext_b} <= {8'hff, 8'h00};
        wr(OFS_PB_DIR, 8'hff);
        tick(3);
        rdc(OFS_PB_DATA, 8'h00);
        wr(OFS_INTERRUPT_CONTROL_REG, 8'h00);
        ext_b <= 8'h0f;
        tick(4);
        `CHK("flag", 1'b0, change_interrupt_flag);
        ext_b <= 8'h4f;
        tick(4);
        `CHK("flag", 1'b1, change_interrupt_flag);
        `CHK("wake", 1'b1, wake_request);
        wr(OFS_INTERRUPT_CONTROL_REG, 8'h00);
        tick(2);
        `CHK("flag", 1'b1, change_interrupt_flag);
        rdc(OFS_PB_DATA, 8'h4f);
        wr(OFS_INTERRUPT_CONTROL_REG, 8'h00);
        tick(2);
        `CHK("flag", 1'b0, change_interrupt_flag);
        $display("test second port done");
        wrap_up();
    end
endmodule // dgp_gpio_top_tb
